// >>> rtl/hsd_i2c_unit.sv
// Purpose: status, shift data, own address and start/stop hold detection
//          for two two-wire serial channels
// Assumes: CLK is the cpu clock, LINK_CLK the fosc/2 sample clock
// Notes: control register and bit-rate logic live outside
//
// Operation
// - status is read-only, usable as a service vector
// - own address with acknowledge enabled sets pending interrupt
// - enabled general call with acknowledge flags and interrupts
// - master interrupts per byte, even after lost arbitration
// - addressed slave interrupts per byte in or out
// - selected slave interrupts on a stop condition
// - data register holds byte to send or received, msb first
// - status bit 6 set on any stop condition
// - status bit 5 marks pending interrupt, cleared by status read
// - status bit 4 shows transmitter role
// - status bit 3 shows another master on the bus
// - status bit 2 shows arbitration lost as master
// - status bit 1 set on not-acknowledge, cleared on acknowledge
// - status bit 0 shows slave role
// - slave responds to seven-bit own address in upper address bits
// - setup registers at d1h and d2h, reset 00h
// - setup bit 7 clear means single sample, low bits ignored
// - setup bit 7 set needs low bits plus one stable samples
// - acknowledge enable clear releases data line during ack clock
`timescale 1ns/1ps

module hsd_i2c_unit
    import hsd_pkg::*;
(
    // cpu clock and reset
    input wire logic CLK,
    input wire logic RESET_N,
    // sample clock for the bus side
    input wire logic LINK_CLK,
    // special function register port
    input wire logic [7:0] SFR_ADDR,
    input wire logic SFR_WR,
    input wire logic SFR_RD,
    input wire logic [7:0] SFR_WDATA,
    output logic [7:0] SFR_RDATA,
    // from the control register outside
    input wire logic [CH_NUM-1:0] ACK_EN,
    input wire logic [CH_NUM-1:0] MASTER_REQ,
    // pending interrupt per channel
    output logic [CH_NUM-1:0] IRQ_REQ,
    // bus pins
    input wire logic [CH_NUM-1:0] SDA_I,
    output logic [CH_NUM-1:0] SDA_O,
    output logic [CH_NUM-1:0] SDA_OE,
    input wire logic [CH_NUM-1:0] SCL_I,
    output logic [CH_NUM-1:0] SCL_O,
    output logic [CH_NUM-1:0] SCL_OE
);

    // ==========================================================
    // read data merge
    logic [7:0] rd_or [0:CH_NUM];
    logic [7:0] ch_rd [0:CH_NUM-1];

    assign rd_or[0] = UNMAPPED_READ;

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            SFR_RDATA <= RDATA_RST;
        end else if (SFR_RD) begin
            SFR_RDATA <= rd_or[CH_NUM];
        end
    end

    // open-drain pins only ever pull low
    assign SDA_O = '0;
    assign SCL_O = '0;

    for (genvar ch = 0; ch < CH_NUM; ch++) begin : g_ch

        // ======================================================
        // cpu side registers
        logic [7:0] setup;
        logic [7:0] own_addr;
        logic [7:0] dat;
        logic pend;
        logic rel;
        logic [LK_W-1:0] lk_m;
        logic [LK_W-1:0] lk_s;
        logic [1:0] tgl_q;
        logic [7:0] status;
        logic [6:0] st_c;
        logic [1:0] tgl_c;
        logic rx_is_c;
        logic [7:0] rx_c;
        logic [LK_W-1:0] lk_link;

        assign {st_c, tgl_c, rx_is_c, rx_c} = lk_s;

        wire hit_setup = SFR_ADDR == SETUP_ADDR[ch];
        wire hit_sta = SFR_ADDR == STA_ADDR[ch];
        wire hit_dat = SFR_ADDR == DAT_ADDR[ch];
        wire hit_adr = SFR_ADDR == ADR_ADDR[ch];
        // status has no write strobe at all
        wire wr_setup = SFR_WR && hit_setup;
        wire wr_dat = SFR_WR && hit_dat;
        wire wr_adr = SFR_WR && hit_adr;
        wire rd_sta = SFR_RD && hit_sta;
        wire byte_ev = tgl_c[1] != tgl_q[1];
        wire stopi_ev = tgl_c[0] != tgl_q[0];

        // bit 5 is live, the rest cross from the bus side
        assign status[STA_GC_BIT] = st_c[6];
        assign status[STA_STOP_BIT] = st_c[5];
        assign status[STA_PEND_BIT] = pend;
        assign status[STA_TX_BIT] = st_c[4];
        assign status[STA_BUSY_BIT] = st_c[3];
        assign status[STA_LOST_BIT] = st_c[2];
        assign status[STA_NACK_BIT] = st_c[1];
        assign status[STA_SLV_BIT] = st_c[0];

        wire [7:0] rd_val = hit_setup ? setup :
                            hit_sta ? status :
                            hit_dat ? dat :
                            hit_adr ? own_addr : UNMAPPED_READ;
        assign ch_rd[ch] = rd_val;
        assign rd_or[ch+1] = rd_or[ch] | ch_rd[ch];
        assign IRQ_REQ[ch] = pend;

        always_ff @(posedge CLK or negedge RESET_N) begin
            if (!RESET_N) begin
                setup <= SETUP_RST;
                own_addr <= ADR_RST;
            end else begin
                if (wr_setup) begin
                    setup <= SFR_WDATA;
                end
                if (wr_adr) begin
                    own_addr <= SFR_WDATA;
                end
            end
        end

        // a received byte wins over a cpu write
        always_ff @(posedge CLK or negedge RESET_N) begin
            if (!RESET_N) begin
                dat <= DAT_RST;
            end else if (byte_ev && rx_is_c) begin
                dat <= rx_c;
            end else if (wr_dat) begin
                dat <= SFR_WDATA;
            end
        end

        // set wins over the read that clears
        always_ff @(posedge CLK or negedge RESET_N) begin
            if (!RESET_N) begin
                pend <= 1'b0;
                rel <= 1'b0;
                tgl_q <= 2'h0;
                lk_m <= '0;
                lk_s <= '0;
            end else begin
                lk_m <= lk_link;
                lk_s <= lk_m;
                tgl_q <= tgl_c;
                if (byte_ev || stopi_ev) begin
                    pend <= 1'b1;
                end else if (rd_sta) begin
                    pend <= 1'b0;
                end
                if (rd_sta && pend) begin
                    rel <= ~rel;
                end
            end
        end

        // ======================================================
        // bus side: synchronisers
        logic [CFG_W-1:0] cfg_m;
        logic [CFG_W-1:0] cfg_s;
        logic [7:0] setup_l;
        logic [7:0] own_l;
        logic [7:0] dat_l;
        logic ack_l;
        logic mreq_l;
        logic rel_s;
        logic rel_q;
        logic sda_m, sda_s, scl_m, scl_s, scl_q;

        // quasi-static config: written only while idle or holding
        assign {setup_l, own_l, dat_l, ack_l, mreq_l, rel_s} = cfg_s;

        always_ff @(posedge LINK_CLK or negedge RESET_N) begin
            if (!RESET_N) begin
                cfg_m <= '0;
                cfg_s <= '0;
                rel_q <= 1'b0;
                {sda_m, sda_s, scl_m, scl_s, scl_q} <= 5'h1f;
            end else begin
                cfg_m <= {setup, own_addr, dat, ACK_EN[ch], MASTER_REQ[ch],
                          rel};
                cfg_s <= cfg_m;
                rel_q <= rel_s;
                sda_m <= SDA_I[ch];
                sda_s <= sda_m;
                scl_m <= SCL_I[ch];
                scl_s <= scl_m;
                scl_q <= scl_s;
            end
        end

        // ======================================================
        // start/stop hold detector
        logic sda_acc;
        logic [7:0] det_cnt;

        wire [7:0] need = setup_l[SETUP_EN_BIT] ?
                          ({1'b0, setup_l[6:0]} + ONE_SAMPLE) :
                          ONE_SAMPLE;
        wire det_diff = scl_s && (sda_s != sda_acc);
        wire [7:0] det_next = det_cnt + ONE_SAMPLE;
        wire det_hit = det_diff && (det_next >= need);
        wire start_c = det_hit && !sda_s;
        wire stop_c = det_hit && sda_s;

        // data may only move while the clock is low, so the level is
        // re-learnt every low phase
        always_ff @(posedge LINK_CLK or negedge RESET_N) begin
            if (!RESET_N) begin
                sda_acc <= 1'b1;
                det_cnt <= 8'h00;
            end else if (!scl_s || !det_diff) begin
                sda_acc <= scl_s ? sda_acc : sda_s;
                det_cnt <= 8'h00;
            end else if (det_hit) begin
                sda_acc <= sda_s;
                det_cnt <= 8'h00;
            end else begin
                det_cnt <= det_next;
            end
        end

        // ======================================================
        // byte engine
        hsd_state_t state;
        logic [7:0] shift;
        logic [2:0] cnt;
        logic master, slave, txm, lost, nack, gc, stop_seen, other_busy;
        logic rw, first, sda_oe, scl_oe, byte_tgl, stopi_tgl;
        logic rx_is;
        logic [7:0] rx_byte;

        wire scl_rise = scl_s && !scl_q;
        wire scl_fall = !scl_s && scl_q;
        wire rel_ev = rel_s != rel_q;
        wire [7:0] rx_next = {shift[6:0], sda_s};
        wire addr_hit = rx_next[7:1] == own_l[7:1];
        wire gc_hit = (rx_next == GC_ADDRESS) && own_l[GC_EN_BIT];
        wire last = cnt == LAST_BIT;
        wire next_tx = master ? (!first || !rw) : txm;

        assign lk_link = {gc, stop_seen, txm, other_busy, lost, nack, slave,
                          byte_tgl, stopi_tgl, rx_is, rx_byte};
        assign SDA_OE[ch] = sda_oe;
        assign SCL_OE[ch] = scl_oe;

        always_ff @(posedge LINK_CLK or negedge RESET_N) begin
            if (!RESET_N) begin
                state <= ST_IDLE;
                shift <= 8'h00;
                cnt <= 3'h0;
                {master, slave, txm, lost, nack, gc} <= 6'h00;
                {stop_seen, other_busy, rw, first} <= 4'h0;
                {sda_oe, scl_oe, byte_tgl, stopi_tgl, rx_is} <= 5'h00;
                rx_byte <= 8'h00;
            end else if (start_c) begin
                {gc, stop_seen, lost, slave} <= 4'h0;
                {sda_oe, scl_oe} <= 2'h0;
                cnt <= 3'h0;
                master <= mreq_l;
                txm <= mreq_l;
                other_busy <= !mreq_l;
                shift <= dat_l;
                rw <= dat_l[0];
                first <= 1'b1;
                state <= mreq_l ? ST_TX : ST_ADDR;
            end else if (stop_c) begin
                stop_seen <= 1'b1;
                stopi_tgl <= stopi_tgl ^ slave;
                {slave, master, txm, other_busy} <= 4'h0;
                {sda_oe, scl_oe} <= 2'h0;
                state <= ST_IDLE;
            end else begin
                case (state)
                    ST_ADDR: begin
                        if (scl_rise) begin
                            shift <= rx_next;
                            cnt <= cnt + 3'h1;
                            if (last && (addr_hit || gc_hit) && ack_l) begin
                                slave <= 1'b1;
                                gc <= gc_hit;
                                txm <= rx_next[0] && !gc_hit;
                                nack <= 1'b0;
                                byte_tgl <= ~byte_tgl;
                                {rx_is, rx_byte} <= {1'b1, rx_next};
                                state <= ST_ACK_OUT;
                            end else if (last) begin
                                state <= ST_IDLE;
                            end
                        end
                    end
                    ST_RX: begin
                        if (scl_rise) begin
                            shift <= rx_next;
                            cnt <= cnt + 3'h1;
                            if (last) begin
                                nack <= !ack_l;
                                byte_tgl <= ~byte_tgl;
                                {rx_is, rx_byte} <= {1'b1, rx_next};
                                state <= ST_ACK_OUT;
                            end
                        end
                    end
                    ST_ACK_OUT: begin
                        if (scl_fall) begin
                            sda_oe <= ack_l;
                            state <= ST_ACK_DRV;
                        end
                    end
                    ST_ACK_DRV: begin
                        if (scl_fall) begin
                            sda_oe <= 1'b0;
                            scl_oe <= 1'b1;
                            state <= ST_HOLD;
                        end
                    end
                    ST_TX: begin
                        // after a lost arbitration keep clocking, drive nothing
                        if (!scl_s) begin
                            sda_oe <= !shift[7] && !lost;
                        end
                        if (scl_rise) begin
                            if (master && !sda_oe && !sda_s) begin
                                lost <= 1'b1;
                            end
                            shift <= {shift[6:0], 1'b1};
                            cnt <= cnt + 3'h1;
                            if (last) begin
                                state <= ST_ACK_IN;
                            end
                        end
                    end
                    ST_ACK_IN: begin
                        if (!scl_s) begin
                            sda_oe <= 1'b0;
                        end
                        if (scl_rise) begin
                            nack <= sda_s;
                            byte_tgl <= ~byte_tgl;
                            rx_is <= 1'b0;
                            state <= ST_ACK_END;
                        end
                    end
                    ST_ACK_END: begin
                        if (scl_fall) begin
                            scl_oe <= 1'b1;
                            state <= ST_HOLD;
                        end
                    end
                    ST_HOLD: begin
                        // clock held low until the status is read
                        if (rel_ev) begin
                            scl_oe <= 1'b0;
                            cnt <= 3'h0;
                            first <= 1'b0;
                            if ((master && lost) || (slave && txm && nack)) begin
                                {master, txm, slave} <= 3'h0;
                                state <= ST_IDLE;
                            end else if (next_tx) begin
                                txm <= 1'b1;
                                shift <= dat_l;
                                sda_oe <= !dat_l[7];
                                state <= ST_TX;
                            end else begin
                                txm <= 1'b0;
                                state <= ST_RX;
                            end
                        end
                    end
                    default: begin
                        state <= ST_IDLE;
                    end
                endcase
            end
        end
    end

endmodule

// >>> rtl/hsd_pkg.sv
// Purpose: constants and types of the serial unit
// Assumes: 8-bit register space, two channels
// Notes: status, data, address offsets sit in three consecutive slots per channel, apart from setup

package hsd_pkg;

    // ==========================================================
    // channel count and register map
    localparam int CH_NUM = 2;
    localparam logic [1:0][7:0] SETUP_ADDR = {8'hd2, 8'hd1};
    localparam logic [1:0][7:0] STA_ADDR = {8'hdb, 8'hd8};
    localparam logic [1:0][7:0] DAT_ADDR = {8'hdc, 8'hd9};
    localparam logic [1:0][7:0] ADR_ADDR = {8'hdd, 8'hda};

    // ==========================================================
    // reset values
    localparam logic [7:0] SETUP_RST = 8'h00;
    localparam logic [7:0] DAT_RST = 8'h00;
    localparam logic [7:0] ADR_RST = 8'h00;
    localparam logic [7:0] RDATA_RST = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // ==========================================================
    // status field positions
    localparam int STA_GC_BIT = 7;
    localparam int STA_STOP_BIT = 6;
    localparam int STA_PEND_BIT = 5;
    localparam int STA_TX_BIT = 4;
    localparam int STA_BUSY_BIT = 3;
    localparam int STA_LOST_BIT = 2;
    localparam int STA_NACK_BIT = 1;
    localparam int STA_SLV_BIT = 0;

    // ==========================================================
    // setup, address and byte constants
    localparam int SETUP_EN_BIT = 7;
    localparam int GC_EN_BIT = 0;
    localparam logic [7:0] ONE_SAMPLE = 8'h01;
    localparam logic [7:0] GC_ADDRESS = 8'h00;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam int CFG_W = 27;
    localparam int LK_W = 18;

    // ==========================================================
    // byte engine states
    typedef enum logic [8:0] {
        ST_IDLE = 9'h001,
        ST_ADDR = 9'h002,
        ST_RX = 9'h004,
        ST_TX = 9'h008,
        ST_ACK_OUT = 9'h010,
        ST_ACK_DRV = 9'h020,
        ST_ACK_IN = 9'h040,
        ST_ACK_END = 9'h080,
        ST_HOLD = 9'h100
    } hsd_state_t;

endpackage

// >>> sim/hsd_bus_master_model.sv
// Purpose: external bus master on two open-drain channels
// Assumes: the bench pulls released lines high
// Notes: honours clock stretching, with a bound
`timescale 1ns/1ps

module hsd_bus_master_model (
    // sample clock and resolved wires
    input wire logic lclk,
    input wire logic [1:0] sda_w,
    input wire logic [1:0] scl_w,
    // pull-low controls
    output logic [1:0] sda_low,
    output logic [1:0] scl_low
);
    localparam int Q = 8;
    initial begin
        sda_low = 2'h0;
        scl_low = 2'h0;
    end
    task automatic rise(input int ch);
        int n;
        n = 0;
        scl_low[ch] <= 1'b0;
        // a slave may stretch the clock; bounded so a hang ends
        while (scl_w[ch] !== 1'b1 && n < 5000) begin
            @(posedge lclk);
            n++;
        end
        repeat (Q) @(posedge lclk);
    endtask
    task automatic fall(input int ch);
        scl_low[ch] <= 1'b1;
        repeat (Q) @(posedge lclk);
    endtask
    task automatic start(input int ch, input int h);
        @(posedge lclk);
        sda_low[ch] <= 1'b1;
        repeat (h) @(posedge lclk);
        fall(ch);
    endtask
    task automatic stop(input int ch);
        sda_low[ch] <= 1'b1;
        repeat (Q) @(posedge lclk);
        rise(ch);
        sda_low[ch] <= 1'b0;
        repeat (2 * Q) @(posedge lclk);
    endtask
    task automatic wbyte(input int ch, input logic [7:0] b,
                         output logic ack);
        for (int i = 7; i >= 0; i--) begin
            sda_low[ch] <= ~b[i];
            repeat (Q) @(posedge lclk);
            rise(ch);
            fall(ch);
        end
        sda_low[ch] <= 1'b0;
        repeat (Q) @(posedge lclk);
        rise(ch);
        ack = sda_w[ch];
        fall(ch);
    endtask
    task automatic rbyte(input int ch, input logic nack,
                         output logic [7:0] b);
        sda_low[ch] <= 1'b0;
        for (int i = 7; i >= 0; i--) begin
            repeat (Q) @(posedge lclk);
            rise(ch);
            b[i] = sda_w[ch];
            fall(ch);
        end
        sda_low[ch] <= ~nack;
        repeat (Q) @(posedge lclk);
        rise(ch);
        fall(ch);
        sda_low[ch] <= 1'b0;
    endtask
endmodule

// >>> sim/hsd_i2c_unit_asserts.sv
// Purpose: port-level checks, mostly channel 0
// Assumes: package register map
// Notes: all checks on CLK; link pins lag by the sync
`timescale 1ns/1ps

module hsd_i2c_unit_chk
    import hsd_pkg::*;
(
    // clock and reset
    input wire logic CLK,
    input wire logic RESET_N,
    // register port
    input wire logic [7:0] SFR_ADDR,
    input wire logic SFR_RD,
    input wire logic [7:0] SFR_RDATA,
    // events and pins
    input wire logic [CH_NUM-1:0] IRQ_REQ,
    input wire logic [CH_NUM-1:0] SDA_O,
    input wire logic [CH_NUM-1:0] SCL_O,
    input wire logic [CH_NUM-1:0] SCL_OE
);
    // ==========================================================
    // decode
    wire logic rd_sta0 = SFR_RD && SFR_ADDR == STA_ADDR[0];
    wire logic rd_sta1 = SFR_RD && SFR_ADDR == STA_ADDR[1];
    wire logic mapped = SFR_ADDR inside {SETUP_ADDR[0], SETUP_ADDR[1],
        STA_ADDR[0], STA_ADDR[1], DAT_ADDR[0], DAT_ADDR[1],
        ADR_ADDR[0], ADR_ADDR[1]};

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);

    // ==========================================================
    // assertions
    a_pend_read0: assert property (
        rd_sta0 |=> SFR_RDATA[STA_PEND_BIT] == $past(IRQ_REQ[0]))
        else $error("read 0 lost pending");
    a_pend_read1: assert property (
        rd_sta1 |=> SFR_RDATA[STA_PEND_BIT] == $past(IRQ_REQ[1]))
        else $error("read 1 lost pending");
    a_irq_clear_cause: assert property (
        $fell(IRQ_REQ[0]) |-> $past(rd_sta0))
        else $error("pending cleared unread");
    a_rdata_stands: assert property (
        !SFR_RD |=> $stable(SFR_RDATA))
        else $error("read data moved unread");
    a_unmapped_zero: assert property (
        SFR_RD && !mapped |=> SFR_RDATA == UNMAPPED_READ)
        else $error("unmapped read not zero");
    a_hold_release: assert property (
        SCL_OE[0] && rd_sta0 && IRQ_REQ[0] |-> ##[1:100] !SCL_OE[0])
        else $error("hold not released");
    a_hold_has_irq: assert property (
        $rose(SCL_OE[0]) |-> IRQ_REQ[0])
        else $error("hold without pending");
    a_pins_open: assert property (
        SDA_O == '0 && SCL_O == '0)
        else $error("bus pin driven high");

    c_irq0: cover property ($rose(IRQ_REQ[0]));
    c_hold1: cover property ($rose(SCL_OE[1]));
    c_rd_pend: cover property (rd_sta0 && IRQ_REQ[0]);
endmodule

bind hsd_i2c_unit hsd_i2c_unit_chk u_chk (
    .CLK(CLK), .RESET_N(RESET_N), .SFR_ADDR(SFR_ADDR), .SFR_RD(SFR_RD),
    .SFR_RDATA(SFR_RDATA), .IRQ_REQ(IRQ_REQ), .SDA_O(SDA_O),
    .SCL_O(SCL_O), .SCL_OE(SCL_OE)
);

// >>> sim/tb_top.sv
// Purpose: self-checking bench of the serial unit
// Assumes: one master model drives both channels
// Notes: expected bytes queued, status from the rules
`timescale 1ns/1ps

module tb_top import hsd_pkg::*; ;
    logic CLK, RESET_N, LINK_CLK, SFR_WR, SFR_RD;
    logic [7:0] SFR_ADDR, SFR_WDATA, SFR_RDATA, b;
    logic [1:0] ACK_EN, MASTER_REQ, IRQ_REQ, SDA_O, SDA_OE, SCL_O, SCL_OE;
    logic [1:0] sda_low, scl_low;
    wire logic [1:0] sda_w = ~(SDA_OE | sda_low);
    wire logic [1:0] scl_w = ~(SCL_OE | scl_low);
    int n_mismatch, comparisons, c;
    logic [6:0] oa;
    logic a;
    logic [7:0] q[$];

    initial begin
        CLK = 1'b0;
        forever #2.5 CLK = ~CLK;
    end
    initial begin
        LINK_CLK = 1'b0;
        #7.3;
        forever #32 LINK_CLK = ~LINK_CLK;
    end
    hsd_i2c_unit DUT (
        .CLK(CLK), .RESET_N(RESET_N), .LINK_CLK(LINK_CLK),
        .SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR), .SFR_RD(SFR_RD),
        .SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA), .ACK_EN(ACK_EN),
        .MASTER_REQ(MASTER_REQ), .IRQ_REQ(IRQ_REQ), .SDA_I(sda_w),
        .SDA_O(SDA_O), .SDA_OE(SDA_OE), .SCL_I(scl_w), .SCL_O(SCL_O),
        .SCL_OE(SCL_OE));
    hsd_bus_master_model PM (.lclk(LINK_CLK), .sda_w(sda_w),
        .scl_w(scl_w), .sda_low(sda_low), .scl_low(scl_low));

    // ==========================================================
    // shared tasks
    task automatic chk(input logic [7:0] g, input logic [7:0] e,
                       input logic [7:0] m);
        comparisons++;
        if ((g & m) !== (e & m)) begin
            n_mismatch++;
            $display("[ERR] t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        @(posedge CLK);
        SFR_ADDR <= ad;
        SFR_WDATA <= d;
        SFR_WR <= 1'b1;
        @(posedge CLK);
        SFR_WR <= 1'b0;
    endtask
    task automatic rc(input logic [7:0] ad, input logic [7:0] e,
                      input logic [7:0] m);
        @(posedge CLK);
        SFR_ADDR <= ad;
        SFR_RD <= 1'b1;
        @(posedge CLK);
        SFR_RD <= 1'b0;
        #1;
        chk(SFR_RDATA, e, m);
    endtask
    task automatic rs(input int ch, input logic [7:0] e, input logic [7:0] m);
        rc(STA_ADDR[ch], e, m);
        chk({7'h0, IRQ_REQ[ch]}, 8'h00, 8'h01);
    endtask
    task automatic wait_irq(input int ch);
        int n;
        n = 0;
        while (IRQ_REQ[ch] !== 1'b1 && n < 5000) begin
            @(posedge CLK);
            n++;
        end
        chk({7'h0, IRQ_REQ[ch]}, 8'h01, 8'h01);
        // past the ack bit, so the hold has begun
        repeat (600) @(posedge CLK);
    endtask
    task automatic txn(input int ch, input int h, input logic [7:0] ab,
                       input logic [7:0] ea, input logic [7:0] es);
        logic k;
        PM.start(ch, h);
        fork
            PM.wbyte(ch, ab, k);
            if (ea == 8'h00) begin
                wait_irq(ch);
                if (ab[0]) wr(DAT_ADDR[ch], q[0]);
                rs(ch, es, 8'hff);
            end
        join
        chk({7'h0, k}, ea, 8'h01);
        chk({7'h0, IRQ_REQ[ch]}, 8'h00, 8'h01);
    endtask
    task automatic dbyte(input int ch);
        logic k;
        q.push_back(8'($urandom));
        fork
            PM.wbyte(ch, q[$], k);
            begin
                wait_irq(ch);
                rs(ch, 8'h29, 8'hff);
            end
        join
        chk({7'h0, k}, 8'h00, 8'h01);
        rc(DAT_ADDR[ch], q.pop_front(), 8'hff);
    endtask
    task automatic stp(input int ch, input logic sel, input logic [7:0] e,
                       input logic [7:0] m);
        fork
            PM.stop(ch);
            if (sel) begin
                wait_irq(ch);
                rs(ch, e, m);
            end
        join
        if (!sel) rs(ch, e, m);
    endtask
    task automatic close_out();
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ==========================================================
    // main sequence
    initial begin
        {SFR_ADDR, SFR_WDATA, SFR_WR, SFR_RD} = '0;
        ACK_EN = 2'h3;
        MASTER_REQ = 2'h0;
        RESET_N = 1'b0;
        n_mismatch = 0;
        comparisons = 0;
        void'($urandom(77302));
        repeat (20) @(posedge CLK);
        RESET_N <= 1'b1;
        repeat (10) @(posedge LINK_CLK);
        for (c = 0; c < 2; c++) begin
            rc(SETUP_ADDR[c], SETUP_RST, 8'hff);
            rc(DAT_ADDR[c], DAT_RST, 8'hff);
            rc(ADR_ADDR[c], ADR_RST, 8'hff);
            rc(STA_ADDR[c], 8'h00, 8'hff);
            b = 8'($urandom);
            wr(SETUP_ADDR[c], b);
            rc(SETUP_ADDR[c], b, 8'hff);
            wr(STA_ADDR[c], 8'($urandom) | 8'h20);
            rc(STA_ADDR[c], 8'h00, 8'hff);
        end
        wr(8'hd4, 8'($urandom));
        rc(8'hd4, UNMAPPED_READ, 8'hff);
        // slave receive, 12-sample start filter
        for (c = 0; c < 2; c++) begin
            oa = {1'b1, 6'($urandom)};
            wr(ADR_ADDR[c], {oa, 1'b0});
            wr(SETUP_ADDR[c], 8'h8b);
            txn(c, 16, {oa, 1'b0}, 8'h00, 8'h29);
            dbyte(c);
            dbyte(c);
            stp(c, 1'b1, 8'h60, 8'hfe);
        end
        c = 1 - int'($urandom % 2);
        wr(ADR_ADDR[c], {oa, 1'b0});
        txn(c, 16, {oa ^ 7'h01, 1'b0}, 8'h01, 8'h00);
        stp(c, 1'b0, 8'h40, 8'h60);
        txn(c, 4, {oa, 1'b0}, 8'h01, 8'h00);
        stp(c, 1'b0, 8'h40, 8'h60);
        wr(SETUP_ADDR[c], 8'h0b);
        txn(c, 4, {oa, 1'b0}, 8'h00, 8'h29);
        stp(c, 1'b1, 8'h60, 8'hfe);
        @(posedge CLK);
        ACK_EN[c] <= 1'b0;
        txn(c, 16, {oa, 1'b0}, 8'h01, 8'h00);
        stp(c, 1'b0, 8'h40, 8'h60);
        @(posedge CLK);
        ACK_EN[c] <= 1'b1;
        wr(ADR_ADDR[c], {oa, 1'b1});
        txn(c, 16, GC_ADDRESS, 8'h00, 8'ha9);
        stp(c, 1'b1, 8'he0, 8'hfe);
        // slave transmit, refused by master
        q.push_back(8'($urandom));
        txn(c, 16, {oa, 1'b1}, 8'h00, 8'h39);
        fork
            PM.rbyte(c, 1'b1, b);
            begin
                wait_irq(c);
                rs(c, 8'h3b, 8'hf6);
            end
        join
        chk(b, q.pop_front(), 8'hff);
        stp(c, 1'b0, 8'h40, 8'h60);
        // master loses arbitration on the first bit
        @(posedge CLK);
        MASTER_REQ[c] <= 1'b1;
        wr(DAT_ADDR[c], 8'hff);
        PM.start(c, 16);
        fork
            PM.wbyte(c, 8'h55, a);
            begin
                wait_irq(c);
                rs(c, 8'h24, 8'h24);
            end
        join
        @(posedge CLK);
        MASTER_REQ[c] <= 1'b0;
        stp(c, 1'b0, 8'h40, 8'h60);
        close_out();
    end

    initial begin
        #400000;
        n_mismatch++;
        close_out();
    end
endmodule
